// >>> design/port_link_map.svh
// register offsets, field positions, reset values and timing counts for port link control
`ifndef PORT_LINK_MAP_SVH
`define PORT_LINK_MAP_SVH

`define NUM_PORTS 4
`define NUM_GIG_PORTS 1
`define LABEL_CHARS 64
`define LABEL_WORDS 16

// register byte offsets; per-port block at PORT_BASE + port*PORT_STRIDE
`define OFS_ALL_CFG 12'h000
`define OFS_PORT_BASE 12'h100
`define PORT_STRIDE_SHIFT 7
`define OFS_CFG 7'h00
`define OFS_STATUS 7'h04
`define OFS_LABEL 7'h40

// cfg field positions
`define CFG_EN_BIT 0
`define CFG_FC_BIT 1
`define CFG_MODE_LSB 4
`define CFG_MODE_W 3
`define CFG_PRIO_LSB 8
`define CFG_PRIO_W 3

// status field positions
`define ST_LINK_BIT 0
`define ST_FULL_BIT 1
`define ST_SPEED_LSB 2
`define ST_CAP_BIT 4
`define ST_NEG_BIT 5

`define PRIO_RESET 3'h0
`define EN_RESET 1'b1
`define FC_RESET 1'b0

// jam length for forced collision: 96 bit times at 100 Mb/s, 10 ns per bit
`define JAM_TIME_NS 960
`define CLK_PERIOD_NS 5
`define JAM_CYCLES ((`JAM_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PAUSE_QUANTA 16'hFFFF

`endif

// >>> design/port_link_pkg.sv
// types shared by the port link control design
package port_link_pkg;

  typedef enum logic [2:0] {
    MODE_AUTO = 3'h0,
    MODE_10_HALF = 3'h1,
    MODE_10_FULL = 3'h2,
    MODE_100_HALF = 3'h3,
    MODE_100_FULL = 3'h4,
    MODE_1000_FULL = 3'h5
  } link_mode_type;

  typedef enum logic [1:0] {
    SPEED_10 = 2'h0,
    SPEED_100 = 2'h1,
    SPEED_1000 = 2'h2
  } speed_type;

  typedef enum logic [3:0] {
    LS_DOWN = 4'h1,
    LS_NEGOTIATE = 4'h2,
    LS_UP = 4'h4,
    LS_FORCED = 4'h8
  } link_state_type;

endpackage

// >>> design/label_mem.sv
// label store: one word of four characters per entry, registered read data
module label_mem
  import port_link_pkg::*;
#(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  // clock
  input wire logic mclk,
  // write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic [3:0] wr_strb,
  // read side
  input wire logic [AW-1:0] rd_addr,
  output logic [31:0] rd_data
);

  logic [31:0] mem [DEPTH];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      for (int b = 0; b < 4; b++) begin
        if (wr_strb[b]) begin
          mem[wr_addr][b*8 +: 8] <= wr_data[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    rd_data <= mem[rd_addr];
  end

endmodule

// >>> design/port_link_control.sv
// per-port link control: enables, speed/duplex selection, flow control and default priority
//
// How it works
// - disabled port forwards nothing; enable resets on
// - mode choices; gigabit only on gigabit ports
// - auto mode negotiates common speed and duplex
// - no peer negotiation: detected speed (100 when a non-gigabit port detects 1000), half duplex
// - forced mode uses configured speed and duplex
// - flow control: pause full, backpressure half
// - full duplex congestion sends a pause
// - half duplex congestion forces a collision
// - untagged incoming frames get default priority
// - all-ports write copies into every port
// - read-only capability type per port
// - per-port label of 64 characters
// - tag priority is three bits, tag four bytes
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`include "port_link_map.svh"
module port_link_control
  import port_link_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // phy side, per port
  input wire logic [`NUM_PORTS-1:0] phy_signal_detect,
  input wire logic [2*`NUM_PORTS-1:0] phy_line_speed,
  input wire logic [`NUM_PORTS-1:0] peer_neg_valid,
  input wire logic [4*`NUM_PORTS-1:0] peer_abilities,
  output logic [`NUM_PORTS-1:0] link_up,
  output logic [`NUM_PORTS-1:0] link_full_duplex,
  output logic [2*`NUM_PORTS-1:0] link_speed,
  // receive congestion and flow control actions
  input wire logic [`NUM_PORTS-1:0] rx_congested,
  input wire logic [`NUM_PORTS-1:0] rx_carrier,
  output logic [`NUM_PORTS-1:0] pause_req,
  output logic [16*`NUM_PORTS-1:0] pause_quanta,
  output logic [`NUM_PORTS-1:0] force_collision,
  // ingress frame priority, per port
  input wire logic [`NUM_PORTS-1:0] rx_frame_valid,
  input wire logic [`NUM_PORTS-1:0] rx_frame_tagged,
  input wire logic [16*`NUM_PORTS-1:0] rx_tag_tci,
  output logic [`NUM_PORTS-1:0] rx_prio_valid,
  output logic [3*`NUM_PORTS-1:0] rx_prio,
  // forwarding gate
  output logic [`NUM_PORTS-1:0] fwd_enable
);

  localparam int NP = `NUM_PORTS;
  localparam int JAM_CYC = `JAM_CYCLES;

  // ****************************************************************
  // reset synchroniser
  // ****************************************************************
  logic rst_meta_reg;
  logic rst_sync_n;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n <= rst_meta_reg;
    end
  end

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic wr_access;
  logic rd_access;
  logic sel_all;
  logic sel_port;
  logic [1:0] port_idx;
  logic [6:0] port_ofs;
  logic port_valid;
  logic [11:0] port_addr;

  assign wr_access = psel && penable && pwrite;
  assign rd_access = psel && penable && !pwrite;
  assign sel_all = (paddr == `OFS_ALL_CFG);
  // port blocks start at the base, so the port number comes from the offset into them
  assign port_addr = paddr - `OFS_PORT_BASE;
  assign sel_port = (paddr >= `OFS_PORT_BASE) && (port_addr[11:9] == 3'h0);
  assign port_idx = port_addr[`PORT_STRIDE_SHIFT +: 2];
  assign port_ofs = port_addr[6:0];
  assign port_valid = sel_port;
  // one wait state so the label memory read data is ready
  logic ack_reg;

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= psel && penable && !ack_reg;
    end
  end

  assign pready = ack_reg;

  logic map_cfg;
  logic map_status;
  logic map_label;
  logic mapped;

  assign map_cfg = port_valid && (port_ofs == `OFS_CFG);
  assign map_status = port_valid && (port_ofs == `OFS_STATUS);
  assign map_label = port_valid && (port_ofs[6] == 1'b1) && (port_ofs[1:0] == 2'h0);
  assign mapped = sel_all || map_cfg || map_status || map_label;
  assign pslverr = ack_reg && !mapped;

  logic wr_commit;
  assign wr_commit = wr_access && ack_reg && mapped;

  // ****************************************************************
  // per-port configuration
  // ****************************************************************
  logic [NP-1:0] en_reg;
  logic [NP-1:0] fc_reg;
  link_mode_type mode_reg [NP];
  logic [2:0] prio_reg [NP];
  logic [31:0] all_cfg_reg;

  function automatic link_mode_type legal_mode(input logic [2:0] req, input logic gig);
    link_mode_type m;
    m = MODE_AUTO;
    if (req <= 3'h4) begin
      m = link_mode_type'(req);
    end else if (req == 3'h5 && gig) begin
      m = MODE_1000_FULL;
    end
    return m;
  endfunction

  // the all-ports register only reads back the cfg fields of the last value written
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      all_cfg_reg <= 32'h0000_0001;
    end else if (wr_commit && sel_all && pstrb[0] && pstrb[1]) begin
      all_cfg_reg <= {21'h0, pwdata[10:8], 1'b0, pwdata[6:4], 2'h0, pwdata[1:0]};
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_cfg
      localparam logic IS_GIG = (gp >= NP - `NUM_GIG_PORTS);
      logic wr_this;
      logic wr_all;
      assign wr_this = wr_commit && map_cfg && (port_idx == 2'(gp));
      assign wr_all = wr_commit && sel_all;

      // a port-level write in the same cycle is impossible: one apb access at a time
      always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          en_reg[gp] <= `EN_RESET;
          fc_reg[gp] <= `FC_RESET;
          mode_reg[gp] <= MODE_AUTO;
          prio_reg[gp] <= `PRIO_RESET;
        end else if ((wr_this || wr_all) && pstrb[0] && pstrb[1]) begin
          en_reg[gp] <= pwdata[`CFG_EN_BIT];
          fc_reg[gp] <= pwdata[`CFG_FC_BIT];
          mode_reg[gp] <= legal_mode(pwdata[`CFG_MODE_LSB +: `CFG_MODE_W], IS_GIG);
          prio_reg[gp] <= pwdata[`CFG_PRIO_LSB +: `CFG_PRIO_W];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // link resolution
  // ****************************************************************
  link_state_type ls_reg [NP];
  logic [NP-1:0] up_reg;
  logic [NP-1:0] full_reg;
  logic [NP-1:0] negotiated_reg;
  speed_type spd_reg [NP];

  generate
    for (gp = 0; gp < NP; gp++) begin : g_link
      localparam logic IS_GIG = (gp >= NP - `NUM_GIG_PORTS);
      // peer abilities: [0] 10 half, [1] 10 full, [2] 100 half, [3] 100 full
      // on a gigabit port, gigabit ability is assumed when line speed reports 1000
      logic [3:0] ab;
      speed_type line_spd;
      assign ab = peer_abilities[gp*4 +: 4];
      assign line_spd = speed_type'(phy_line_speed[gp*2 +: 2]);

      always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          ls_reg[gp] <= LS_DOWN;
          up_reg[gp] <= 1'b0;
          full_reg[gp] <= 1'b0;
          negotiated_reg[gp] <= 1'b0;
          spd_reg[gp] <= SPEED_10;
        end else begin
          case (ls_reg[gp])
            LS_DOWN: begin
              up_reg[gp] <= 1'b0;
              if (phy_signal_detect[gp] && en_reg[gp]) begin
                ls_reg[gp] <= (mode_reg[gp] == MODE_AUTO) ? LS_NEGOTIATE : LS_FORCED;
              end
            end
            LS_NEGOTIATE: begin
              up_reg[gp] <= 1'b1;
              ls_reg[gp] <= LS_UP;
              if (peer_neg_valid[gp]) begin
                negotiated_reg[gp] <= 1'b1;
                if (IS_GIG && line_spd == SPEED_1000) begin
                  spd_reg[gp] <= SPEED_1000;
                  full_reg[gp] <= 1'b1;
                end else if (ab[3]) begin
                  spd_reg[gp] <= SPEED_100;
                  full_reg[gp] <= 1'b1;
                end else if (ab[2]) begin
                  spd_reg[gp] <= SPEED_100;
                  full_reg[gp] <= 1'b0;
                end else begin
                  spd_reg[gp] <= SPEED_10;
                  full_reg[gp] <= ab[1];
                end
              end else begin
                negotiated_reg[gp] <= 1'b0;
                spd_reg[gp] <= (!IS_GIG && line_spd == SPEED_1000) ? SPEED_100 : line_spd;
                full_reg[gp] <= 1'b0;
              end
            end
            LS_FORCED: begin
              up_reg[gp] <= 1'b1;
              ls_reg[gp] <= LS_UP;
              negotiated_reg[gp] <= 1'b0;
              case (mode_reg[gp])
                MODE_10_FULL: begin
                  spd_reg[gp] <= SPEED_10;
                  full_reg[gp] <= 1'b1;
                end
                MODE_100_HALF: begin
                  spd_reg[gp] <= SPEED_100;
                  full_reg[gp] <= 1'b0;
                end
                MODE_100_FULL: begin
                  spd_reg[gp] <= SPEED_100;
                  full_reg[gp] <= 1'b1;
                end
                MODE_1000_FULL: begin
                  spd_reg[gp] <= SPEED_1000;
                  full_reg[gp] <= 1'b1;
                end
                default: begin
                  spd_reg[gp] <= SPEED_10;
                  full_reg[gp] <= 1'b0;
                end
              endcase
            end
            LS_UP: begin
              // losing the line or disabling restarts resolution; a new mode waits for the next link-up
              if (!phy_signal_detect[gp] || !en_reg[gp]) begin
                ls_reg[gp] <= LS_DOWN;
                up_reg[gp] <= 1'b0;
              end
            end
            default: begin
              ls_reg[gp] <= LS_DOWN;
            end
          endcase
        end
      end

      assign link_up[gp] = up_reg[gp];
      assign link_full_duplex[gp] = full_reg[gp];
      assign link_speed[gp*2 +: 2] = spd_reg[gp];
      assign fwd_enable[gp] = en_reg[gp] && up_reg[gp];
    end
  endgenerate

  // ****************************************************************
  // flow control and priority
  // ****************************************************************
  logic [NP-1:0] pause_reg;
  logic [NP-1:0] jam_reg;
  logic [NP-1:0] rx_pv_reg;
  logic [2:0] rx_prio_reg [NP];

  generate
    for (gp = 0; gp < NP; gp++) begin : g_flow
      logic [7:0] jam_cnt_reg;
      logic active;
      assign active = fc_reg[gp] && up_reg[gp] && en_reg[gp];

      // pause is a level held while congested; the mac repeats the frame as needed
      always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          pause_reg[gp] <= 1'b0;
        end else begin
          pause_reg[gp] <= active && full_reg[gp] && rx_congested[gp];
        end
      end

      // jam starts only while the sender is on the wire, then runs one whole jam length whatever the carrier does
      always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          jam_reg[gp] <= 1'b0;
          jam_cnt_reg <= 8'h00;
        end else if (jam_reg[gp]) begin
          if (jam_cnt_reg == 8'(JAM_CYC - 1)) begin
            jam_reg[gp] <= 1'b0;
          end
          jam_cnt_reg <= jam_cnt_reg + 8'h01;
        end else if (active && !full_reg[gp] && rx_congested[gp] && rx_carrier[gp]) begin
          jam_reg[gp] <= 1'b1;
          jam_cnt_reg <= 8'h00;
        end
      end

      // priority is tci[15:13]; frames drop to nothing on a disabled port
      always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          rx_pv_reg[gp] <= 1'b0;
          rx_prio_reg[gp] <= 3'h0;
        end else begin
          rx_pv_reg[gp] <= rx_frame_valid[gp] && en_reg[gp];
          if (rx_frame_valid[gp]) begin
            rx_prio_reg[gp] <= rx_frame_tagged[gp] ? rx_tag_tci[gp*16+13 +: 3] : prio_reg[gp];
          end
        end
      end

      assign pause_req[gp] = pause_reg[gp];
      assign pause_quanta[gp*16 +: 16] = `PAUSE_QUANTA;
      assign force_collision[gp] = jam_reg[gp];
      assign rx_prio_valid[gp] = rx_pv_reg[gp];
      assign rx_prio[gp*3 +: 3] = rx_prio_reg[gp];
    end
  endgenerate

  // ****************************************************************
  // label storage and read mux
  // ****************************************************************
  logic [31:0] label_rd;
  logic lbl_wr;

  assign lbl_wr = wr_commit && map_label;

  label_mem #(.DEPTH(NP * `LABEL_WORDS), .AW(6)) u_label (
    .mclk(mclk),
    .wr_en(lbl_wr),
    .wr_addr({port_idx, port_ofs[5:2]}),
    .wr_data(pwdata),
    .wr_strb(pstrb),
    .rd_addr({port_idx, port_ofs[5:2]}),
    .rd_data(label_rd)
  );

  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (sel_all) begin
      rd_mux = all_cfg_reg;
    end else if (map_cfg) begin
      rd_mux[`CFG_EN_BIT] = en_reg[port_idx];
      rd_mux[`CFG_FC_BIT] = fc_reg[port_idx];
      rd_mux[`CFG_MODE_LSB +: `CFG_MODE_W] = mode_reg[port_idx];
      rd_mux[`CFG_PRIO_LSB +: `CFG_PRIO_W] = prio_reg[port_idx];
    end else if (map_status) begin
      rd_mux[`ST_LINK_BIT] = up_reg[port_idx];
      rd_mux[`ST_FULL_BIT] = full_reg[port_idx];
      rd_mux[`ST_SPEED_LSB +: 2] = spd_reg[port_idx];
      rd_mux[`ST_CAP_BIT] = (32'(port_idx) >= 32'(NP - `NUM_GIG_PORTS));
      rd_mux[`ST_NEG_BIT] = negotiated_reg[port_idx];
    end else if (map_label) begin
      rd_mux = label_rd;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_access && !ack_reg) begin
      prdata <= rd_mux;
    end
  end

endmodule

// >>> verif/port_link_control_props.sv
// assertion checker for the port link control top ports
`include "port_link_map.svh"
module port_link_control_props (
  // clock, reset and apb answer
  input wire logic mclk, rst_n, psel, penable, pready, pslverr,
  // link state
  input wire logic [`NUM_PORTS-1:0] phy_signal_detect, link_up, link_full_duplex, fwd_enable,
  input wire logic [2*`NUM_PORTS-1:0] link_speed,
  // flow control
  input wire logic [`NUM_PORTS-1:0] pause_req, force_collision,
  input wire logic [16*`NUM_PORTS-1:0] pause_quanta,
  // ingress priority
  input wire logic [`NUM_PORTS-1:0] rx_frame_valid, rx_frame_tagged, rx_prio_valid,
  input wire logic [16*`NUM_PORTS-1:0] rx_tag_tci,
  input wire logic [3*`NUM_PORTS-1:0] rx_prio
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // **************************************
  // jam length counter, port 0
  // **************************************
  logic [8:0] jam_cnt;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) jam_cnt <= 9'h000;
    else if (force_collision[0]) jam_cnt <= jam_cnt + 9'h001;
    else jam_cnt <= 9'h000;
  end
  // **************************************
  // properties
  // **************************************
  a_fwd_needs_link: assert property ((fwd_enable & ~link_up) == 4'h0)
    else $error("forwarding without link");
  a_fast_no_gig: assert property (link_up[0] |-> link_speed[1:0] != 2'h2)
    else $error("fast port at gigabit speed");
  a_link_delay: assert property ($rose(link_up[0]) |-> $past(phy_signal_detect[0], 2))
    else $error("link up without line signal");
  a_pause_full: assert property (pause_req[0] |-> link_up[0] && link_full_duplex[0])
    else $error("pause outside full duplex");
  a_pause_quanta: assert property (pause_quanta == {4{16'hFFFF}})
    else $error("pause quanta wrong");
  a_jam_half: assert property ($rose(force_collision[0]) |-> !link_full_duplex[0])
    else $error("jam in full duplex");
  a_jam_length: assert property ($fell(force_collision[0]) |-> jam_cnt == 9'h0C0)
    else $error("jam length wrong");
  a_prio_pulse: assert property (rx_prio_valid == $past(rx_frame_valid))
    else $error("priority valid timing wrong");
  a_tag_prio: assert property (rx_frame_valid[0] && rx_frame_tagged[0] |=> rx_prio[2:0] == $past(rx_tag_tci[15:13]))
    else $error("tagged priority wrong");
  a_apb_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("apb wait state wrong");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  c_pause: cover property ($rose(pause_req[0]));
  c_jam: cover property ($fell(force_collision[0]));
  c_slverr: cover property (pslverr);
endmodule

bind port_link_control port_link_control_props u_props (.mclk, .rst_n, .psel, .penable, .pready, .pslverr,
  .phy_signal_detect, .link_up, .link_full_duplex, .fwd_enable, .link_speed, .pause_req, .force_collision,
  .pause_quanta, .rx_frame_valid, .rx_frame_tagged, .rx_prio_valid, .rx_tag_tci, .rx_prio);

// >>> verif/link_peer.sv
// peer ethernet port model on the line side of every port
module link_peer (
  // actions of the switch toward the peer
  input wire logic [3:0] pause_req, force_collision,
  // line signals seen by the switch
  output logic [3:0] phy_signal_detect, peer_neg_valid, rx_carrier,
  output logic [7:0] phy_line_speed,
  output logic [15:0] peer_abilities
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] det = 4'h0, neg = 4'h0, sending = 4'h0;
  logic [7:0] spd = 8'h00;
  logic [15:0] abil = 16'h0000;
  // a released line shows the inverse so a stale value is never trusted
  assign phy_line_speed = spd ^ {{2{~det[3]}}, {2{~det[2]}}, {2{~det[1]}}, {2{~det[0]}}};
  assign peer_abilities = abil ^ {{4{~neg[3]}}, {4{~neg[2]}}, {4{~neg[1]}}, {4{~neg[0]}}};
  assign phy_signal_detect = det;
  assign peer_neg_valid = neg;
  // the sender holds off while paused or jammed
  assign rx_carrier = sending & ~pause_req & ~force_collision;
  // a forced peer gets the same speed as the port, chosen by the caller
  task automatic peer(input int p, input logic on, input logic [1:0] s, input logic n, input logic [3:0] a);
    spd[2*p+:2] <= s;
    abil[4*p+:4] <= a;
    neg[p] <= n & on;
    det[p] <= on;
  endtask
endmodule

// >>> verif/port_link_control_bench.sv
// self-checking bench for port link control
`include "port_link_map.svh"
module port_link_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, last_err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hF, phy_signal_detect, peer_neg_valid, rx_carrier, link_up, link_full_duplex;
  logic [3:0] pause_req, force_collision, rx_prio_valid, fwd_enable;
  logic [3:0] rx_congested = 4'h0, rx_frame_valid = 4'h0, rx_frame_tagged = 4'h0;
  logic [7:0] phy_line_speed, link_speed;
  logic [15:0] peer_abilities;
  logic [63:0] pause_quanta, rx_tag_tci = 64'h0;
  logic [11:0] rx_prio;
  logic [31:0] seed = 32'h0000_6FB6;
  logic [31:0] cfg_m [4];
  logic [31:0] lbl_m [16];
  int error_cnt = 0, total_checks = 0;

  initial forever #2.5 mclk = ~mclk;

  port_link_control u_dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .phy_signal_detect, .phy_line_speed, .peer_neg_valid, .peer_abilities, .link_up, .link_full_duplex,
    .link_speed, .rx_congested, .rx_carrier, .pause_req, .pause_quanta, .force_collision, .rx_frame_valid,
    .rx_frame_tagged, .rx_tag_tci, .rx_prio_valid, .rx_prio, .fwd_enable);
  link_peer u_peer (.pause_req, .force_collision, .phy_signal_detect, .peer_neg_valid, .rx_carrier,
    .phy_line_speed, .peer_abilities);

  // ********************************
  // helpers
  // ********************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // unused bits drop, unsupported modes fall back to auto
  function automatic logic [31:0] legal(input int p, input logic [31:0] d);
    logic [31:0] v;
    v = d & 32'h0000_0773;
    if (v[6:4] > 3'h5 || (v[6:4] == 3'h5 && p != 3)) v[6:4] = 3'h0;
    return v;
  endfunction
  function automatic logic [11:0] base(input int p);
    return 12'h100 + 12'(p) * 12'h080;
  endfunction
  task automatic wait_clk(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    apb(1'b1, a, d, s, r);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x, input logic [31:0] msk);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, 4'hF, r);
    check(r & msk, x);
  endtask
  task automatic setcfg(input int p, input logic [31:0] d);
    wr(base(p), d, 4'hF);
    cfg_m[p] = legal(p, d);
  endtask
  task automatic link_case(input int p, input logic [2:0] m, input logic [1:0] ls, input logic n,
                           input logic [3:0] ab);
    logic [2:0] e;
    setcfg(p, (cfg_m[p] & 32'hFFFF_FF8F) | {25'h0, m, 4'h1});
    if (m != 3'h0) e = {m != 3'h1 && m != 3'h3, m == 3'h5 ? 2'h2 : m > 3'h2 ? 2'h1 : 2'h0};
    else if (!n) e = {1'b0, (ls == 2'h2 && p != 3) ? 2'h1 : ls};
    else if (p == 3 && ls == 2'h2) e = 3'h6;
    else e = ab[3] ? 3'h5 : ab[2] ? 3'h1 : ab[1] ? 3'h4 : 3'h0;
    u_peer.peer(p, 1'b1, m == 3'h0 ? ls : e[1:0], n, ab);
    wait_clk(4);
    check({link_up[p], link_full_duplex[p], link_speed[2*p+:2], fwd_enable[p]}, {1'b1, e, 1'b1});
    rdc(base(p) + 12'h004, {m == 3'h0 && n, p == 3, e[1:0], e[2], 1'b1}, 32'h3F);
    setcfg(p, cfg_m[p] & 32'hFFFF_FFFE);
    wait_clk(4);
    check({link_up[p], fwd_enable[p]}, 2'b00);
    u_peer.peer(p, 1'b0, 2'h0, 1'b0, 4'h0);
    setcfg(p, cfg_m[p] | 32'h1);
  endtask
  task automatic flow_case(input logic [2:0] m, input logic fc);
    int n;
    setcfg(0, {25'h0, m, 2'b0, fc, 1'b1});
    u_peer.peer(0, 1'b1, 2'h1, 1'b0, 4'h0);
    u_peer.sending[0] <= 1'b1;
    rx_congested[0] <= 1'b1;
    wait_clk(6);
    check(pause_req[0], fc && m == 3'h4);
    // the first jam began before the wait ended: let it run out and time a whole one
    n = 0;
    while (force_collision[0] === 1'b1 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    n = 0;
    while (force_collision[0] !== 1'b1 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    n = 0;
    while (force_collision[0] === 1'b1 && n < 400) begin
      @(posedge mclk);
      n++;
    end
    check(n, fc && m == 3'h3 ? `JAM_CYCLES : 0);
    rx_congested[0] <= 1'b0;
    u_peer.sending[0] <= 1'b0;
    wait_clk(4);
    check(pause_req[0], 1'b0);
    u_peer.peer(0, 1'b0, 2'h0, 1'b0, 4'h0);
    wait_clk(4);
  endtask
  task automatic prio_case(input int p);
    logic [2:0] d;
    logic [15:0] t;
    d = 3'(rnd());
    setcfg(p, {21'h0, d, 8'h01});
    for (int k = 0; k < 4; k++) begin
      t = 16'(rnd());
      rx_frame_valid[p] <= 1'b1;
      rx_frame_tagged[p] <= k[0];
      rx_tag_tci[16*p+:16] <= t;
      @(posedge mclk);
      rx_frame_valid[p] <= 1'b0;
      @(posedge mclk);
      check({rx_prio_valid[p], rx_prio[3*p+:3]}, {1'b1, k[0] ? t[15:13] : d});
    end
  endtask

  // ********************************
  // main sequence
  // ********************************
  initial begin
    wait_clk(2);
    rst_n <= 1'b1;
    wait_clk(4);
    for (int p = 0; p < 4; p++) begin
      cfg_m[p] = 32'h1;
      rdc(base(p), cfg_m[p], 32'hFFFF_FFFF);
      rdc(base(p) + 12'h004, {p == 3, 4'h0}, 32'h1F);
    end
    $display("test reset values done");
    wr(12'h000, 32'hFFFF_FF53, 4'hF);
    for (int p = 0; p < 4; p++) cfg_m[p] = legal(p, 32'hFFFF_FF53);
    setcfg(1, 32'h0000_0021);
    wr(base(2), 32'h0, 4'h1);
    for (int p = 0; p < 4; p++) rdc(base(p), cfg_m[p], 32'hFFFF_FFFF);
    rdc(12'hFFC, 32'h0, 32'hFFFF_FFFF);
    check(last_err, 1'b1);
    wr(12'h000, 32'h1, 4'hF);
    for (int p = 0; p < 4; p++) cfg_m[p] = 32'h1;
    $display("test all ports done");
    for (int m = 1; m < 6; m++) link_case(3, 3'(m), 2'h0, 1'b0, 4'h0);
    for (int m = 1; m < 5; m++) link_case(0, 3'(m), 2'h0, 1'b0, 4'h0);
    for (int k = 0; k < 6; k++) begin
      link_case(k % 4, 3'h0, 2'(rnd() % 3), 1'b1, 4'(rnd() | 1));
      link_case(k % 4, 3'h0, 2'(rnd() % 3), 1'b0, 4'hF);
    end
    $display("test link modes done");
    flow_case(3'h4, 1'b1);
    flow_case(3'h3, 1'b1);
    flow_case(3'h4, 1'b0);
    flow_case(3'h3, 1'b0);
    $display("test flow control done");
    for (int p = 0; p < 4; p++) prio_case(p);
    $display("test priority done");
    for (int w = 0; w < 16; w++) begin
      lbl_m[w] = rnd();
      wr(base(2) + 12'h040 + 12'(4 * w), lbl_m[w], 4'hF);
    end
    wr(base(2) + 12'h04C, 32'hA5A5_A5A5, 4'h2);
    lbl_m[3][15:8] = 8'hA5;
    for (int w = 0; w < 16; w++) rdc(base(2) + 12'h040 + 12'(4 * w), lbl_m[w], 32'hFFFF_FFFF);
    $display("test label done");
    print_verdict();
  end

  // run is under two thousand cycles; this bound only catches a hang
  initial begin
    wait_clk(40000);
    error_cnt++;
    print_verdict();
  end
endmodule
